// file: hdl/tfi_pkg.sv
// Operation
// RQ1: answer custom code ABh with info reply
// RQ2: reader sends flags, code, maker, UID, CRC
// RQ3: error reply is flags and error code
// RQ4: ok reply: flags, pointer, conditions, lock, features
// RQ5: fields show settings live at query time
// RQ6: bit one means feature enabled
// RQ7: low page read bit0, write bit1
// RQ8: high page read bit4, write bit5
// RQ9: lock byte: family, alarm, dsfid, boundary
// RQ10: feature bits: memory guard, counter, alarm id
// RQ11: feature bits: alarm guard, family guard
// RQ12: feature bits: scan read, alarm select
// RQ13: feature bits: signature read and guard
// RQ14: feature bits: quiet, privacy, destroy
// RQ15: top feature bit flags further word
// RQ16: transmission error gives silence
// RQ17: unsupported: 0Fh if addressed, else silent; the code also answers 0Fh when selected and the tag is selected
// RQ18: inventory or extension flag: silent
// RQ19: bit n sits at index n-1
// RQ20: fixed feature word, low byte first
package tfi_pkg;
  // air command and answer codes
  localparam logic [7:0] CMD_SYS_INFO   = 8'hab;
  localparam logic [7:0] ERR_NOT_SUPP   = 8'h0f;
  localparam logic [7:0] FLAGS_OK       = 8'h00;
  localparam logic [7:0] FLAGS_ERR      = 8'h01;
  // request flag bit positions
  localparam int FLG_INVENTORY = 2;
  localparam int FLG_PROTO_EXT = 3;
  localparam int FLG_SELECT    = 4;
  localparam int FLG_ADDRESS   = 5;
  // request lengths in bytes, crc already stripped
  localparam logic [3:0] LEN_PLAIN = 4'h3;
  localparam logic [3:0] LEN_ADDR  = 4'hb;
  // reply lengths in bytes, crc appended downstream
  localparam logic [3:0] RSP_OK_LEN  = 4'h8;
  localparam logic [3:0] RSP_ERR_LEN = 4'h2;
  // valid field bits, reserved ones read zero
  localparam logic [7:0]  COND_MASK = 8'h33;
  localparam logic [7:0]  LOCK_MASK = 8'h0f;
  localparam logic [31:0] FEAT_MASK = 32'h0000_377f;
  localparam logic [31:0] FEAT_DEF  = 32'h0000_377f;
  // register byte addresses
  localparam logic [7:0] REG_SETTINGS = 8'h00;
  localparam logic [7:0] REG_FEATURES = 8'h04;
  localparam logic [7:0] REG_STATUS   = 8'h08;
  localparam logic [7:0] REG_CONTROL  = 8'h0c;
  localparam logic [31:0] SETTINGS_RST = 32'h0000_0000;
  localparam logic [31:0] CONTROL_RST  = 32'h0000_0001;
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // received frame from the bit decoder
  typedef struct packed {
    logic       sof;       // new frame begins
    logic       byte_vld;  // one payload byte
    logic [7:0] data;
    logic       eof;       // frame ended
    logic       crc_ok;    // no crc, coding or count error
  } tfi_rx_t;

  // reply byte stream toward the frame encoder
  typedef struct packed {
    logic       valid;
    logic [7:0] data;
    logic       last;
  } tfi_tx_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,  // collecting request bytes
    ST_DROP = 2'b01,  // reply sent, wait for next sof
    ST_SEND = 2'b10   // streaming the reply
  } tfi_state_t;
endpackage

// file: hdl/tfi_responder.sv
// The address map and register access over AXI4-Lite were chosen for this implementation.
`timescale 1ns/1ps
module tfi_responder #(
  parameter logic [7:0]  MFG_CODE  = 8'h5a,  // arbitrary neutral value
  parameter logic [31:0] FEAT_WORD = tfi_pkg::FEAT_DEF
) (
  input  wire logic            ref_clk,
  input  wire logic            nrst,
  input  wire tfi_pkg::tfi_rx_t rx,
  input  wire logic [63:0]     tag_uid,
  input  wire logic            tag_selected,
  output tfi_pkg::tfi_tx_t     tx,
  input  wire logic            tx_ready,
  input  wire logic [7:0]      s_axi_awaddr,
  input  wire logic            s_axi_awvalid,
  output logic                 s_axi_awready,
  input  wire logic [31:0]     s_axi_wdata,
  input  wire logic [3:0]      s_axi_wstrb,
  input  wire logic            s_axi_wvalid,
  output logic                 s_axi_wready,
  output logic [1:0]           s_axi_bresp,
  output logic                 s_axi_bvalid,
  input  wire logic            s_axi_bready,
  input  wire logic [7:0]      s_axi_araddr,
  input  wire logic            s_axi_arvalid,
  output logic                 s_axi_arready,
  output logic [31:0]          s_axi_rdata,
  output logic [1:0]           s_axi_rresp,
  output logic                 s_axi_rvalid,
  input  wire logic            s_axi_rready
);
  import tfi_pkg::*;

  // whole block state in one record
  typedef struct packed {
    tfi_state_t      st;
    logic [3:0]      cnt;       // request bytes seen
    logic            ovf;       // more bytes than any legal request
    logic [10:0][7:0] req;      // flags, code, maker, uid lsb first
    logic [7:0][7:0] rsp;       // reply bytes, index 0 sent first
    logic [3:0]      idx;       // reply byte on offer
    logic [3:0]      len;       // reply length
    logic [31:0]     settings;  // live pointer, conditions, lock
    logic            enable;    // responder on
    logic [7:0]      n_ok;      // good replies sent
    logic [7:0]      n_err;     // error replies sent
    logic [7:0]      n_drop;    // frames met with silence
    logic            aw_have;
    logic [7:0]      aw_addr;
    logic            w_have;
    logic [31:0]     w_data;
    logic [3:0]      w_strb;
    logic            bvalid;
    logic [1:0]      bresp;
    logic            rvalid;
    logic [31:0]     rdata;
    logic [1:0]      rresp;
  } tfi_regs_t;

  tfi_regs_t r;       // registered state
  tfi_regs_t next_r;  // next state

  // register address check, used by both bus paths
  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == REG_SETTINGS) || (a == REG_FEATURES) ||
             (a == REG_STATUS) || (a == REG_CONTROL);
  endfunction

  // byte lane merge for partial writes
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0]  st);
    for (int i = 0; i < 4; i++) begin
      merge[i*8 +: 8] = st[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
    end
  endfunction

  // live fields, reserved bits forced low
  logic [7:0]  boundary;   // protect_boundary_block
  logic [7:0]  conditions; // page_access_conditions
  logic [7:0]  lock_byte;  // lock bits
  logic [31:0] feat;       // fixed feature word
  assign boundary   = r.settings[7:0];
  assign conditions = r.settings[15:8] & COND_MASK;  // [RQ7] [RQ8] [RQ6]
  assign lock_byte  = r.settings[23:16] & LOCK_MASK; // [RQ9] [RQ6]
  // extension bit cleared: no further word exists
  assign feat       = FEAT_WORD &  // [RQ10] [RQ11] [RQ12] [RQ19]
                      FEAT_MASK;   // [RQ13] [RQ14] [RQ15]

  // request decode, settled when eof arrives
  logic       addressed;  // address flag set
  logic       selected;   // select flag set
  logic       quiet_flag; // inventory or protocol extension
  logic       len_ok;     // byte count fits the addressing
  logic       uid_ok;     // our uid, or no uid needed
  logic       is_query;   // our custom code and maker
  logic       go_ok;      // send the info reply
  logic       go_err;     // send the error reply
  assign addressed  = r.req[0][FLG_ADDRESS];
  assign selected   = r.req[0][FLG_SELECT];
  assign quiet_flag = r.req[0][FLG_INVENTORY] | r.req[0][FLG_PROTO_EXT];
  assign len_ok     = !r.ovf &&
                      (r.cnt == (addressed ? LEN_ADDR : LEN_PLAIN));
  assign uid_ok     = !addressed || (r.req[10:3] == tag_uid);
  assign is_query   = (r.req[1] == CMD_SYS_INFO) &&
                      (r.req[2] == MFG_CODE);        // [RQ1]
  // selected frames reach only the selected tag
  assign go_ok  = rx.eof && rx.crc_ok && len_ok && uid_ok &&
                  (!selected || tag_selected) && r.enable &&
                  is_query && !quiet_flag;            // [RQ1] [RQ18]
  // unsupported option answered only when addressed or selected
  assign go_err = rx.eof && rx.crc_ok && len_ok && uid_ok &&
                  (!selected || tag_selected) && r.enable &&
                  !is_query && !quiet_flag &&
                  (addressed || selected);            // [RQ17] [RQ18]

  // bus write accept when both halves are in
  logic wr_fire;
  logic rd_fire;
  assign wr_fire = r.aw_have && r.w_have && !r.bvalid;
  assign rd_fire = s_axi_arvalid && s_axi_arready;

  // next-state logic for the whole block
  always_comb begin
    next_r = r;
    case (r.st)
      ST_IDLE: begin
        // any sof restarts the request buffer
        if (rx.sof) begin
          next_r.cnt = 4'h0;
          next_r.ovf = 1'b0;
        end else if (rx.byte_vld) begin
          if (r.cnt == LEN_ADDR) begin
            next_r.ovf = 1'b1;  // too long, counted as bit-count error
          end else begin
            next_r.req[r.cnt] = rx.data;
            next_r.cnt        = r.cnt + 4'h1;
          end
        end else if (go_ok) begin
          // snapshot of the settings now in force
          next_r.rsp = {feat[31:24], feat[23:16], feat[15:8], feat[7:0],
                        lock_byte, conditions, boundary,
                        FLAGS_OK};                    // [RQ4] [RQ5] [RQ20]
          next_r.len = RSP_OK_LEN;
          next_r.idx = 4'h0;
          next_r.st  = ST_SEND;
        end else if (go_err) begin
          next_r.rsp = {48'h0, ERR_NOT_SUPP, FLAGS_ERR};  // [RQ3] [RQ17]
          next_r.len = RSP_ERR_LEN;
          next_r.idx = 4'h0;
          next_r.st  = ST_SEND;
        end else if (rx.eof) begin
          // bad crc, count, or not for us: stay silent
          next_r.n_drop = r.n_drop + 8'h1;            // [RQ16]
          next_r.cnt    = 4'h0;
          next_r.ovf    = 1'b0;
        end
      end
      ST_DROP: begin
        // hold off until a fresh frame starts
        if (rx.sof) begin
          next_r.cnt = 4'h0;
          next_r.ovf = 1'b0;
          next_r.st  = ST_IDLE;
        end
      end
      ST_SEND: begin
        // advance on each accepted byte
        if (tx_ready) begin
          if (r.idx == r.len - 4'h1) begin
            if (r.len == RSP_OK_LEN) begin
              next_r.n_ok = r.n_ok + 8'h1;
            end else begin
              next_r.n_err = r.n_err + 8'h1;
            end
            next_r.cnt = 4'h0;
            next_r.ovf = 1'b0;
            // frames heard while talking are lost; wait for next sof
            next_r.st  = ST_DROP;
          end else begin
            next_r.idx = r.idx + 4'h1;
          end
        end
      end
      default: begin
        next_r.st = ST_IDLE;
      end
    endcase

    // bus write address and data taken in either order
    if (s_axi_awvalid && s_axi_awready) begin
      next_r.aw_have = 1'b1;
      next_r.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_r.w_have = 1'b1;
      next_r.w_data = s_axi_wdata;
      next_r.w_strb = s_axi_wstrb;
    end
    if (wr_fire) begin
      next_r.aw_have = 1'b0;
      next_r.w_have  = 1'b0;
      next_r.bvalid  = 1'b1;
      next_r.bresp   = mapped(r.aw_addr) ? RESP_OKAY : RESP_SLVERR;
      if (r.aw_addr == REG_SETTINGS) begin
        next_r.settings = merge(r.settings, r.w_data, r.w_strb);
      end else if (r.aw_addr == REG_CONTROL && r.w_strb[0]) begin
        next_r.enable = r.w_data[0];
      end
    end else if (r.bvalid && s_axi_bready) begin
      next_r.bvalid = 1'b0;
    end

    // bus read, answered one cycle after address
    if (rd_fire) begin
      next_r.rvalid = 1'b1;
      next_r.rresp  = mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      case (s_axi_araddr)
        REG_SETTINGS: next_r.rdata = {8'h0, lock_byte, conditions,
                                      boundary};
        REG_FEATURES: next_r.rdata = feat;
        REG_STATUS:   next_r.rdata = {r.n_drop, r.n_err, r.n_ok,
                                      6'h0, r.st};
        REG_CONTROL:  next_r.rdata = {31'h0, r.enable};
        default:      next_r.rdata = 32'h0;
      endcase
    end else if (r.rvalid && s_axi_rready) begin
      next_r.rvalid = 1'b0;
    end
  end

  // single register stage, synchronous reset
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      r          <= '0;
      r.st       <= ST_IDLE;
      r.settings <= SETTINGS_RST;
      r.enable   <= CONTROL_RST[0];
      r.bresp    <= RESP_OKAY;
      r.rresp    <= RESP_OKAY;
    end else begin
      r <= next_r;
    end
  end

  // outputs straight from state
  assign tx.valid      = (r.st == ST_SEND);
  assign tx.data       = r.rsp[r.idx[2:0]];
  assign tx.last       = (r.st == ST_SEND) && (r.idx == r.len - 4'h1);
  assign s_axi_awready = !r.aw_have && !r.bvalid;
  assign s_axi_wready  = !r.w_have && !r.bvalid;
  assign s_axi_bvalid  = r.bvalid;
  assign s_axi_bresp   = r.bresp;
  assign s_axi_arready = !r.rvalid;
  assign s_axi_rvalid  = r.rvalid;
  assign s_axi_rdata   = r.rdata;
  assign s_axi_rresp   = r.rresp;

  // reply kind, used by checks only
  logic is_err_rsp;
  assign is_err_rsp = (r.len == RSP_ERR_LEN);

  // a good reply always starts with clear flags
  property p_ok_flags;
    @(posedge ref_clk) disable iff (!nrst)
      (tx.valid && r.idx == 4'h0 && !is_err_rsp) |-> tx.data == FLAGS_OK;
  endproperty
  a_ok_flags: assert property (p_ok_flags) // [RQ4]
    else $error("ok reply flags not zero");

  // error reply: error flag then code 0Fh, then last
  property p_err_frame;
    @(posedge ref_clk) disable iff (!nrst)
      (tx.valid && r.idx == 4'h0 && is_err_rsp && tx_ready) |->
        tx.data == FLAGS_ERR ##1
        (tx.valid && tx.last && tx.data == ERR_NOT_SUPP);
  endproperty
  a_err_frame: assert property (p_err_frame) // [RQ3]
    else $error("error reply malformed");

  // good reply ends on the eighth byte
  property p_ok_last;
    @(posedge ref_clk) disable iff (!nrst)
      (tx.valid && tx.last && !is_err_rsp) |-> r.idx == 4'h7;
  endproperty
  a_ok_last: assert property (p_ok_last) // [RQ4]
    else $error("ok reply length wrong");

  // feature low byte goes out fifth
  property p_feat_order;
    @(posedge ref_clk) disable iff (!nrst)
      (tx.valid && !is_err_rsp && r.idx == 4'h4) |-> tx.data == feat[7:0];
  endproperty
  a_feat_order: assert property (p_feat_order) // [RQ20]
    else $error("feature byte order wrong");

  // no further word, so the top bit is low
  property p_ext_clear;
    @(posedge ref_clk) disable iff (!nrst)
      (tx.valid && !is_err_rsp && r.idx == 4'h7) |-> !tx.data[7];
  endproperty
  a_ext_clear: assert property (p_ext_clear) // [RQ15]
    else $error("extension bit set");

  // reserved condition bits stay low
  property p_cond_rsv;
    @(posedge ref_clk) disable iff (!nrst)
      (tx.valid && !is_err_rsp && r.idx == 4'h2) |->
        (tx.data & ~COND_MASK) == 8'h00;
  endproperty
  a_cond_rsv: assert property (p_cond_rsv) // [RQ8]
    else $error("reserved condition bit set");

  // pointer equals the setting at query time
  property p_live_ptr;
    @(posedge ref_clk) disable iff (!nrst)
      (r.st == ST_IDLE && go_ok && !rx.sof && !rx.byte_vld) |=>
        r.rsp[1] == $past(boundary) && r.rsp[3] == $past(lock_byte);
  endproperty
  a_live_ptr: assert property (p_live_ptr) // [RQ5]
    else $error("reply fields not live");

  // spoiled frame leaves the link silent
  property p_crc_silent;
    @(posedge ref_clk) disable iff (!nrst)
      (r.st == ST_IDLE && rx.eof && !rx.crc_ok && !rx.sof &&
       !rx.byte_vld) |=> !tx.valid [*2];
  endproperty
  a_crc_silent: assert property (p_crc_silent) // [RQ16]
    else $error("reply to bad frame");

  // inventory or extension flag never answered
  property p_quiet;
    @(posedge ref_clk) disable iff (!nrst)
      (r.st == ST_IDLE && rx.eof && quiet_flag && !rx.sof &&
       !rx.byte_vld) |=> !tx.valid;
  endproperty
  a_quiet: assert property (p_quiet) // [RQ18]
    else $error("reply despite inventory flag");

  // main scenarios
  c_ok_reply: cover property (@(posedge ref_clk) disable iff (!nrst)
    tx.valid && tx.last && tx_ready && !is_err_rsp);
  c_err_reply: cover property (@(posedge ref_clk) disable iff (!nrst)
    tx.valid && tx.last && tx_ready && is_err_rsp);
  c_bad_crc: cover property (@(posedge ref_clk) disable iff (!nrst)
    r.st == ST_IDLE && rx.eof && !rx.crc_ok);
endmodule

// file: testbench/tfi_reader_model.sv
`timescale 1ns/1ps
// reader side of the air link: frames requests, takes reply bytes
module tfi_reader_model
  import tfi_pkg::*;
(
  input  wire logic              ref_clk,
  output tfi_pkg::tfi_rx_t       rx,
  input  wire tfi_pkg::tfi_tx_t  tx,
  output logic                   tx_ready
);
  // idle link at time zero
  initial begin
    rx = '0;
    tx_ready = 1'b0;
  end

  // one request frame, then collect the reply under a bounded wait
  task automatic xfer(input logic [7:0] req[$], input logic good,
                      input int stall, output logic [7:0] rsp[$]);
    rsp = {};
    rx.sof <= 1'b1;  // frame opens with sof
    @(posedge ref_clk);
    rx.sof <= 1'b0;
    // flags, code, maker, optional uid, one byte per cycle
    for (int i = 0; i < req.size(); i++) begin
      rx.byte_vld <= 1'b1;
      rx.data <= req[i];
      @(posedge ref_clk);
    end
    rx.byte_vld <= 1'b0;
    rx.data <= ~rx.data;  // released data no longer holds the last byte
    rx.eof <= 1'b1;
    rx.crc_ok <= good;    // crc check result rides with eof
    @(posedge ref_clk);
    rx.eof <= 1'b0;
    rx.crc_ok <= ~good;
    // slow reader takes one byte in three to stress the hold
    for (int n = 0; n < 40; n++) begin
      tx_ready <= (stall == 0) || (n % 3 == 2);
      @(posedge ref_clk);
      if (tx.valid && tx_ready) begin
        rsp.push_back(tx.data);
        if (tx.last)
          break;
      end
    end
    tx_ready <= 1'b0;
  endtask
endmodule

// file: testbench/tfi_responder_tb.sv
`timescale 1ns/1ps
module tfi_responder_tb;
  import tfi_pkg::*;
  typedef logic [7:0] tfi_bq_t[$];
  localparam logic [7:0]  MFG  = 8'h5a;  // arbitrary maker code
  localparam logic [63:0] UID  = 64'h0123_4567_89ab_cdef;
  // bits 1-7, 9-11, 13-14 set; reserved and extension clear
  localparam logic [31:0] FEAT = 32'h0000_377f;
  logic          ref_clk, nrst, tag_selected, tx_ready;
  tfi_rx_t       rx;
  tfi_tx_t       tx;
  logic [7:0]    awaddr, araddr;
  logic [31:0]   wdata, rdata;
  logic [3:0]    wstrb;
  logic [1:0]    bresp, rresp;
  logic          awvalid, awready, wvalid, wready, bvalid, bready;
  logic          arvalid, arready, rvalid, rready;
  int            mismatches, cmp_count, cycles;

  tfi_responder #(.MFG_CODE(MFG), .FEAT_WORD(FEAT)) DUT (
    .ref_clk(ref_clk), .nrst(nrst), .rx(rx), .tag_uid(UID),
    .tag_selected(tag_selected), .tx(tx), .tx_ready(tx_ready),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready));

  tfi_reader_model rdr (.ref_clk(ref_clk), .rx(rx), .tx(tx),
                        .tx_ready(tx_ready));

  // 100 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  // hang guard, far above the few hundred cycles needed
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 5000) begin
      mismatches++;
      complete_run();
    end
  end

  task automatic complete_run;
    if (mismatches == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, exp, input string m);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH %0t %s seen %h exp %h", $time, m, seen, exp);
    end
  endtask

  // write: both halves offered together, each dropped once taken
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                        output logic [1:0] resp);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    // no cycle count assumed: only the hang guard ends this wait
    forever begin
      @(posedge ref_clk);
      if (awvalid && awready)
        awvalid <= 1'b0;
      if (wvalid && wready)
        wvalid <= 1'b0;
      if (bvalid) begin
        resp = bresp;
        break;
      end
    end
    bready <= 1'b0;
    // one edge passes so a next call never reassigns bready at once
    @(posedge ref_clk);
  endtask

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d,
                        output logic [1:0] resp);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    // no cycle count assumed: only the hang guard ends this wait
    forever begin
      @(posedge ref_clk);
      if (arvalid && arready)
        arvalid <= 1'b0;
      if (rvalid) begin
        d = rdata;
        resp = rresp;
        break;
      end
    end
    rready <= 1'b0;
    // one edge passes so a next call never reassigns rready at once
    @(posedge ref_clk);
  endtask

  // request bytes; uid appended low byte first when addressed
  function automatic tfi_bq_t req(input logic [7:0] fl, cd,
                                  input logic [63:0] id);
    tfi_bq_t q;
    q = {fl, cd, MFG};
    if (fl[5])
      for (int i = 0; i < 8; i++)
        q.push_back(id[8*i +: 8]);
    return q;
  endfunction

  // good reply: reserved bits forced low, feature word low byte first
  function automatic tfi_bq_t ok_rsp(input logic [31:0] s);
    return {8'h00, s[7:0], s[15:8] & 8'h33, s[23:16] & 8'h0f,
            FEAT[7:0], FEAT[15:8], FEAT[23:16], FEAT[31:24]};
  endfunction

  task automatic cmp_rsp(input tfi_bq_t got, exp);
    check(32'(got.size()), 32'(exp.size()), "reply length");
    for (int i = 0; i < exp.size() && i < got.size(); i++)
      check({24'h0, got[i]}, {24'h0, exp[i]}, "reply byte");
  endtask

  // registers: read-only word, reset value, unmapped place, enable
  task automatic t_regs;
    logic [31:0] d;
    logic [1:0]  rs;
    tfi_bq_t     r;
    axi_rd(REG_FEATURES, d, rs);
    check(d, FEAT, "feature word");
    axi_rd(REG_CONTROL, d, rs);
    check(d, 32'h1, "control reset");
    axi_rd(REG_STATUS, d, rs);
    check(d, 32'h0, "status after reset");
    axi_rd(8'h10, d, rs);
    check(32'(rs), 32'(RESP_SLVERR), "unmapped read");
    axi_wr(8'h10, 32'hffff_ffff, rs);
    check(32'(rs), 32'(RESP_SLVERR), "unmapped write");
    axi_wr(REG_CONTROL, 32'h0, rs);
    check(32'(rs), 32'(RESP_OKAY), "control write");
    rdr.xfer(req(8'h00, 8'hab, UID), 1'b1, 0, r);
    check(32'(r.size()), 32'h0, "disabled reply");
    // the ignored frame lands in the silent count, state back to idle
    axi_rd(REG_STATUS, d, rs);
    check(d, 32'h0100_0000, "silent count");
    axi_wr(REG_CONTROL, 32'h1, rs);
  endtask

  // each lock bit and condition bits 0, 1 and 4 alone, settings changed between queries
  task automatic t_fields;
    logic [31:0] tbl [4] = '{32'h0001_01a5, 32'h0002_0200,
                             32'h0004_10ff, 32'h00f8_ef5c};
    logic [1:0]  rs;
    tfi_bq_t     r;
    for (int i = 0; i < 4; i++) begin
      axi_wr(REG_SETTINGS, tbl[i], rs);
      rdr.xfer(req(8'h00, 8'hab, UID), 1'b1, i % 2, r);
      cmp_rsp(r, ok_rsp(tbl[i]));
    end
  endtask

  // addressed and selected queries, wrong uid, not selected
  task automatic t_addr;
    tfi_bq_t r;
    rdr.xfer(req(8'h20, 8'hab, UID), 1'b1, 1, r);
    cmp_rsp(r, ok_rsp(32'h00f8_ef5c));
    rdr.xfer(req(8'h20, 8'hab, ~UID), 1'b1, 0, r);
    check(32'(r.size()), 32'h0, "foreign uid");
    tag_selected <= 1'b1;
    rdr.xfer(req(8'h10, 8'hab, UID), 1'b1, 0, r);
    cmp_rsp(r, ok_rsp(32'h00f8_ef5c));
    tag_selected <= 1'b0;
    rdr.xfer(req(8'h10, 8'hab, UID), 1'b1, 0, r);
    check(32'(r.size()), 32'h0, "not selected");
  endtask

  // spoiled frame and unsupported code under each addressing mode
  task automatic t_err;
    logic [7:0] fl [5] = '{8'h20, 8'h10, 8'h00, 8'h24, 8'h28};
    logic       er [5] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b0};
    tfi_bq_t    r;
    tfi_bq_t    lq;
    rdr.xfer(req(8'h00, 8'hab, UID), 1'b0, 0, r);
    check(32'(r.size()), 32'h0, "crc error");
    // one byte past the addressed length: bit-count error, silent
    lq = req(8'h20, 8'hab, UID);
    lq.push_back(8'h00);
    rdr.xfer(lq, 1'b1, 0, r);
    check(32'(r.size()), 32'h0, "overlong frame");
    tag_selected <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      rdr.xfer(req(fl[i], 8'hac, UID), 1'b1, 0, r);
      if (er[i])
        cmp_rsp(r, {8'h01, 8'h0f});
      else
        check(32'(r.size()), 32'h0, "silent");
    end
    tag_selected <= 1'b0;
  endtask

  // reset, then the scenarios in turn
  initial begin
    nrst = 1'b0;
    tag_selected = 1'b0;
    {awaddr, araddr, wdata, wstrb} = '0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    repeat (12) @(posedge ref_clk);
    nrst <= 1'b1;
    @(posedge ref_clk);
    t_regs();
    t_fields();
    t_addr();
    t_err();
    complete_run();
  end
endmodule
